// file: design/crc16_pkg.sv
// Purpose: Shared constants for the byte serial checksum unit
// Assumes: Classic Wishbone slave with 32-bit data, one register per aligned word
// Notes: Registers are eight bits wide in the low lane, upper bits read as zero
package crc16_pkg;
    // ****************************************************
    // Register map (byte addresses)
    // ****************************************************
    localparam logic [3:0] GENERATOR_SELECT_CONTROL_ADDR = 4'h0;
    localparam logic [3:0] CHECKSUM_INPUT_BYTE_ADDR = 4'h4;
    localparam logic [3:0] CHECKSUM_RESULT_LOW_ADDR = 4'h8;
    localparam logic [3:0] CHECKSUM_RESULT_HIGH_ADDR = 4'hc;
    // ****************************************************
    // Fields and reset values
    // ****************************************************
    localparam int GENERATOR_SELECT_BIT = 0;
    localparam logic [7:0] INPUT_BYTE_RESET = 8'h00;
    localparam logic [15:0] CHECKSUM_RESET = 16'h0000;
    localparam logic GENERATOR_SELECT_RESET = 1'b0;
    // ****************************************************
    // Generator constants
    // ****************************************************
    localparam logic [15:0] GENERATOR_CCITT = 16'h1021;
    localparam logic [15:0] GENERATOR_CRC16 = 16'h8005;
    localparam int BITS_PER_BYTE = 8;
    // Depth of the byte queue in front of the checksum engine
    localparam int BYTE_FIFO_DEPTH = 16;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
endpackage

// file: design/byte_fifo.sv
// Purpose: Small flip-flop FIFO with valid and ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes: Full and empty are exact; a push while full is refused by ready low
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // Refuse depths the pointer wrap cannot serve, at elaboration
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_params
        $error("byte_fifo: DEPTH must be a power of two of at least 2");
    end

    // Handshakes on both sides
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign in_ready_o = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != '0);
    assign out_data_o = store[rd_ptr];

    // Storage write
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            store[wr_ptr] <= in_data_i;
        end
    end

    // Pointers and fill level
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // byte_fifo

// file: design/byte_serial_crc16_unit.sv
// Purpose: Byte serial 16-bit checksum unit behind a classic Wishbone slave
// Assumes: One system clock, synchronous reset, software feeds bytes in order
// Notes: Input bytes queue in a FIFO; the engine folds one byte per clock
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
// Function
// [RULE_01] A running 16-bit checksum is kept and advanced by each input byte.
// [RULE_02] Control bit zero clear picks x16+x12+x5+1, set picks x16+x15+x2+1.
// [RULE_03] Only those two generators exist; no other polynomial can be loaded.
// [RULE_04] Each input byte write folds that byte into the held checksum, replacing it.
// [RULE_05] One byte is folded in a single clock once it reaches the engine.
// [RULE_06] The byte is first XORed into the checksum's upper eight bits.
// [RULE_07] Each step shifts the temporary value left with a zero entering.
// [RULE_08] When the bit shifted out is one, the value is XORed with 8005h or 1021h.
// [RULE_09] The shift and XOR step runs eight times before the result is stored.
// [RULE_10] The high result register reads and writes checksum bits 15 to 8.
// [RULE_11] The low result register reads and writes checksum bits 7 to 0.
// [RULE_12] Input byte, both result bytes and the select bit reset to zero.
// [RULE_13] Control bits 7 to 1 always read as zero.
// [RULE_14] Software clears the result pair and selects a generator before a new sum.
// [RULE_15] For program memory, software feeds each word low byte then high byte.
// [RULE_16] No reflection and no final XOR; the register value is the result.
// [RULE_17] A direct result write loads the checksum so the next byte continues from it.
module byte_serial_crc16_unit
    import crc16_pkg::*;
#(
    parameter int FIFO_DEPTH = BYTE_FIFO_DEPTH
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic busy_o
);
    // ****************************************************
    // Declarations
    // ****************************************************
    logic generator_select;
    logic [7:0] checksum_input_byte;
    logic [15:0] running_checksum;
    logic [15:0] next_checksum;
    logic req;
    logic wr_lane0;
    logic hit_ctrl;
    logic hit_in;
    logic hit_lo;
    logic hit_hi;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic engine_take;
    logic ack_stall;

    // Parameter sanity, refused at elaboration
    if (FIFO_DEPTH < 2) begin : g_bad_depth
        $error("byte_serial_crc16_unit: FIFO_DEPTH must be at least 2");
    end

    // ****************************************************
    // Bus decode
    // ****************************************************
    // New request only when no ack is pending, so each access is taken once
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_lane0 = req && wb_we_i && wb_sel_i[0];
    always_comb begin
        hit_ctrl = 1'b0;
        hit_in = 1'b0;
        hit_lo = 1'b0;
        hit_hi = 1'b0;
        if (wb_adr_i == GENERATOR_SELECT_CONTROL_ADDR) begin
            hit_ctrl = 1'b1;
        end else if (wb_adr_i == CHECKSUM_INPUT_BYTE_ADDR) begin
            hit_in = 1'b1;
        end else if (wb_adr_i == CHECKSUM_RESULT_LOW_ADDR) begin
            hit_lo = 1'b1;
        end else if (wb_adr_i == CHECKSUM_RESULT_HIGH_ADDR) begin
            hit_hi = 1'b1;
        end
    end

    // An input write waits for room in the queue; back-pressure holds ack off
    assign fifo_in_valid = wr_lane0 && hit_in;
    assign ack_stall = fifo_in_valid && !fifo_in_ready;

    // Result reads and writes must see every queued byte folded in first
    assign engine_take = fifo_out_valid;

    // ****************************************************
    // Byte queue
    // ****************************************************
    byte_fifo #(
        .WIDTH(BITS_PER_BYTE),
        .DEPTH(FIFO_DEPTH)
    ) u_byte_fifo (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(wb_dat_i[7:0]),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(engine_take),
        .out_data_o(fifo_out_data)
    );

    // ****************************************************
    // Checksum engine
    // ****************************************************
    // Eight unrolled steps in one clock; trades logic depth for one-cycle fold
    always_comb begin
        logic [15:0] temp;
        logic [15:0] taps;
        temp = '0;
        taps = generator_select ? GENERATOR_CRC16 : GENERATOR_CCITT; // [RULE_02] [RULE_03]
        temp = running_checksum ^ {fifo_out_data, 8'h00}; // [RULE_06]
        for (int i = 0; i < BITS_PER_BYTE; i++) begin // [RULE_09]
            if (temp[15]) begin
                temp = {temp[14:0], 1'b0} ^ taps; // [RULE_07] [RULE_08]
            end else begin
                temp = {temp[14:0], 1'b0}; // [RULE_07]
            end
        end
        next_checksum = temp; // [RULE_16]
    end

    // Running checksum: direct loads only when the queue is empty
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            running_checksum <= CHECKSUM_RESET; // [RULE_12]
        end else if (engine_take) begin
            running_checksum <= next_checksum; // [RULE_01] [RULE_04] [RULE_05]
        end else if (wr_lane0 && hit_lo) begin
            running_checksum[7:0] <= wb_dat_i[7:0]; // [RULE_11] [RULE_17]
        end else if (wr_lane0 && hit_hi) begin
            running_checksum[15:8] <= wb_dat_i[7:0]; // [RULE_10] [RULE_17]
        end
    end

    // ****************************************************
    // Registers
    // ****************************************************
    // Input byte keeps the last value written for readback
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            checksum_input_byte <= INPUT_BYTE_RESET; // [RULE_12]
        end else if (fifo_in_valid && fifo_in_ready) begin
            checksum_input_byte <= wb_dat_i[7:0];
        end
    end

    // Generator select; a change waits until queued bytes are folded
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            generator_select <= GENERATOR_SELECT_RESET; // [RULE_12]
        end else if (wr_lane0 && hit_ctrl && !fifo_out_valid) begin
            generator_select <= wb_dat_i[GENERATOR_SELECT_BIT]; // [RULE_02]
        end
    end

    // ****************************************************
    // Bus answer
    // ****************************************************
    // Ack one cycle after the request, later while the queue blocks it
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= UNMAPPED_READ;
        end else begin
            wb_ack_o <= 1'b0;
            if (req && !ack_stall && !((hit_ctrl || hit_lo || hit_hi) && fifo_out_valid)) begin
                wb_ack_o <= 1'b1;
                wb_dat_o <= UNMAPPED_READ;
                if (hit_ctrl) begin
                    wb_dat_o <= {31'h00000000, generator_select}; // [RULE_13]
                end else if (hit_in) begin
                    wb_dat_o <= {24'h000000, checksum_input_byte};
                end else if (hit_lo) begin
                    wb_dat_o <= {24'h000000, running_checksum[7:0]}; // [RULE_11]
                end else if (hit_hi) begin
                    wb_dat_o <= {24'h000000, running_checksum[15:8]}; // [RULE_10]
                end
            end
        end
    end

    // Busy while bytes are still queued or an input byte write with lane 0 selected is presented
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= fifo_out_valid || fifo_in_valid;
        end
    end
endmodule // byte_serial_crc16_unit

// file: test/crc16_unit_asserts.sv
// Purpose: Port checker for the byte serial checksum unit
// Assumes: Master holds each request until it samples ack
// Notes: Shadows the control and input registers to check readback
`timescale 1ns/1ps
module crc16_unit_asserts
    import crc16_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic busy_o
);
    logic [7:0] last_in;
    logic sel_bit;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    // Shadow copies, taken at the edge that samples ack, one edge after the write lands
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            last_in <= 8'h00;
            sel_bit <= 1'b0;
        end else if (wb_ack_o && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == CHECKSUM_INPUT_BYTE_ADDR) last_in <= wb_dat_i[7:0];
            if (wb_adr_i == GENERATOR_SELECT_CONTROL_ADDR) sel_bit <= wb_dat_i[0];
        end
    end
    // ****************************************************
    // Properties
    // ****************************************************
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    property p_ack_bound; wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:20] wb_ack_o; endproperty
    property p_upper_zero; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
    property p_ctrl_read;
        wb_ack_o && !wb_we_i && wb_adr_i == GENERATOR_SELECT_CONTROL_ADDR
            |-> wb_dat_o[7:0] == {7'h00, sel_bit};
    endproperty
    property p_in_read;
        wb_ack_o && !wb_we_i && wb_adr_i == CHECKSUM_INPUT_BYTE_ADDR |-> wb_dat_o[7:0] == last_in;
    endproperty
    property p_dat_hold; !wb_ack_o |-> $stable(wb_dat_o); endproperty
    property p_reset; $fell(sys_rst_i) |-> wb_dat_o == 32'h0 && !wb_ack_o && !busy_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack wider than one cycle");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_ack_bound: assert property (p_ack_bound) else $error("ack too late");
    a_upper_zero: assert property (p_upper_zero) else $error("upper data set");
    a_ctrl_read: assert property (p_ctrl_read) else $error("control readback");
    a_in_read: assert property (p_in_read) else $error("input readback");
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
    a_reset: assert property (p_reset) else $error("reset state");
    c_input_write: cover property (wb_ack_o && wb_we_i && wb_adr_i == CHECKSUM_INPUT_BYTE_ADDR);
    c_high_read: cover property (wb_ack_o && !wb_we_i && wb_adr_i == CHECKSUM_RESULT_HIGH_ADDR);
    c_select_set: cover property (wb_ack_o && sel_bit);
endmodule // crc16_unit_asserts
bind byte_serial_crc16_unit crc16_unit_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o));

// file: test/tb.sv
// Purpose: Self-checking bench for the checksum unit
// Assumes: Wishbone master waits for ack, bounded only by the run timeout
// Notes: Bus timing keeps the byte queue short, so it is never driven full
`timescale 1ns/1ps
module tb;
    import crc16_pkg::*;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, wb_ack_o, busy_o, pol, bq;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [15:0] sum, wrd;
    // Single byte results from a cleared pair, bytes 00h to 07h, per generator
    logic [15:0] one_sum [2][8] = '{'{16'h0000, 16'h1021, 16'h2042, 16'h3063,
                                     16'h4084, 16'h50a5, 16'h60c6, 16'h70e7},
                                   '{16'h0000, 16'h8005, 16'h800f, 16'h000a,
                                     16'h801b, 16'h001e, 16'h0014, 16'h8011}};
    logic [7:0] b;
    logic [15:0] seq_sum [2][4] = '{'{16'hff9f, 16'hbbc3, 16'ha367, 16'hd0fa},
                                    '{16'h0110, 16'h91f1, 16'hf2de, 16'h5c43}};
    logic [7:0] seq [4] = '{8'h78, 8'h56, 8'h34, 8'h12};
    int n_fail = 0, checked = 0, cycles = 0;
    byte_serial_crc16_unit #(.FIFO_DEPTH(16)) DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(wb_ack_o), .busy_o(busy_o));
    // ****************************************************
    // Bus, model and compare helpers
    // ****************************************************
    initial forever #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end
    // One classic cycle; upper data and sel bits are random since the unit ignores them
    task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d, input logic s0);
        @(posedge sys_clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= {3'($urandom), s0};
        wdat <= {24'($urandom), d};
        // Ack ends this wait; only the run timeout bounds it
        do begin
            @(posedge sys_clk_i);
        end while (wb_ack_o !== 1'b1);
        q = rdat;
        bq = busy_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    function automatic logic [15:0] fold(logic [15:0] c, logic [7:0] d, logic p);
        c = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            c = {c[14:0], 1'b0} ^ (c[15] ? (p ? GENERATOR_CRC16 : GENERATOR_CCITT) : 16'h0000);
        end
        return c;
    endfunction
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("Error read data expected %h seen %h", e, g);
        end
    endtask
    // Busy as sampled at the ack edge of the last access
    task automatic chk_busy(input logic e);
        checked++;
        if (bq !== e) begin
            n_fail++;
            $display("Error busy expected %b seen %b", e, bq);
        end
    endtask
    task automatic chk_sum(input logic [15:0] e);
        logic [15:0] g;
        xfer(1'b0, CHECKSUM_RESULT_LOW_ADDR, 8'h00, 1'b1);
        g[7:0] = q[7:0];
        xfer(1'b0, CHECKSUM_RESULT_HIGH_ADDR, 8'h00, 1'b1);
        g[15:8] = q[7:0];
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("Error checksum expected %h seen %h", e, g);
        end
    endtask
    // Garbage in control bits 7..1 on purpose
    task automatic load(input logic [15:0] v, input logic p);
        xfer(1'b1, GENERATOR_SELECT_CONTROL_ADDR, {7'($urandom), p}, 1'b1);
        xfer(1'b1, CHECKSUM_RESULT_LOW_ADDR, v[7:0], 1'b1);
        xfer(1'b1, CHECKSUM_RESULT_HIGH_ADDR, v[15:8], 1'b1);
        sum = v;
        pol = p;
    endtask
    task automatic feed(input logic [7:0] d);
        xfer(1'b1, CHECKSUM_INPUT_BYTE_ADDR, d, 1'b1);
        chk_busy(1'b1);
        sum = fold(sum, d, pol);
    endtask
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        void'($urandom(32'hab7d6710));
        repeat (5) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        for (int a = 0; a < 4; a++) begin
            xfer(1'b0, 4'(a * 4), 8'h00, 1'b1);
            chk(32'h0, q);
        end
        xfer(1'b1, 4'h2, 8'hff, 1'b1);
        xfer(1'b0, 4'h2, 8'h00, 1'b1);
        chk(32'h0, q);
        $display("reset and map test done");
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 8; i++) begin
                load(16'h0000, p[0]);
                feed(8'(i));
                chk_sum(one_sum[p][i]);
            end
            load(16'h0000, p[0]);
            for (int i = 0; i < 4; i++) begin
                feed(seq[i]);
                chk_sum(seq_sum[p][i]);
            end
        end
        $display("single byte and sequence test done");
        for (int k = 0; k < 30; k++) begin
            load(16'($urandom), 1'($urandom));
            for (int i = 0; i < 1 + k % 20; i++) begin
                b = 8'($urandom);
                feed(b);
            end
            xfer(1'b1, CHECKSUM_INPUT_BYTE_ADDR, ~b, 1'b0);
            chk_busy(1'b0);
            chk_sum(sum);
            xfer(1'b0, CHECKSUM_INPUT_BYTE_ADDR, 8'h00, 1'b1);
            chk({24'h0, b}, q);
            xfer(1'b0, GENERATOR_SELECT_CONTROL_ADDR, 8'h00, 1'b1);
            chk({31'h0, pol}, q);
        end
        $display("random stream test done");
        // Program words go in low byte first, then high byte
        load(16'h0000, 1'($urandom));
        for (int w = 0; w < 8; w++) begin
            wrd = 16'($urandom);
            feed(wrd[7:0]);
            feed(wrd[15:8]);
        end
        chk_sum(sum);
        $display("program memory word test done");
        // Reset in mid-run must clear state left by the stream above
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        for (int a = 0; a < 4; a++) begin
            xfer(1'b0, 4'(a * 4), 8'h00, 1'b1);
            chk(32'h0, q);
        end
        $display("mid-run reset test done");
        report_and_stop();
    end
endmodule // tb
